// ---- rtl/rpm_map_formatter.sv ----
/*
  Receive payload mapper, error counter clear strobe, signaling frame delay and
  PCM transmit/receive timebases with derived sync outputs.
  Assumes a synchronous processor write port on MCLK, HDSL framer signals on MCLK,
  and PCM bit clocks and transmit sync arriving as pins from another domain.
*/
`default_nettype none
`include "rpm_defines.svh"
module rpm_map_formatter
  import rpm_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // Processor write port
  input wire logic MPU_WR,
  input wire logic [7:0] MPU_ADDR,
  input wire logic [7:0] MPU_WDATA,
  // Received HDSL payload
  input wire logic PAYLOAD_VALID,
  input wire logic PAYLOAD_BLOCK_START,
  input wire logic [7:0] PAYLOAD_BYTE,
  input wire logic RECEIVE_STORE_FLUSH,
  output logic STORE_WR,
  output logic [7:0] STORE_DATA,
  // Error counters
  output logic ERR_COUNT_CLEAR,
  // Signaling grooming
  input wire logic SIGNALING_GROOM_ENABLE,
  output logic SIG_FRAME0_MARK,
  // Transmit PCM side
  input wire logic TX_BIT_CLOCK,
  input wire logic TX_MULTIFRAME_SYNC_IN,
  output logic DERIVED_TX_SYNC_OUT,
  output logic [8:0] TX_BIT_POS,
  output logic [5:0] TX_FRAME_POS,
  output logic TX_SLOT_STROBE,
  output logic TX_6MS_MARK,
  // Receive PCM side
  input wire logic RX_BIT_CLOCK,
  input wire logic HDSL_RX_6MS_SYNC,
  output logic RX_MULTIFRAME_SYNC_OUT,
  output logic [8:0] RX_BIT_POS,
  output logic [5:0] RX_FRAME_POS,
  output logic RX_SLOT_STROBE,
  output logic RX_6MS_MARK
);

  logic [`RPM_MAP_W-1:0] map_r;
  logic [3:0] sig_dly_r;
  rpm_bits_t tx_bofs_r, rx_bofs_r, fbits_r;
  rpm_frm_t tx_fofs_r, rx_fofs_r, mflen_r, mfcnt_r;
  logic wr_errclr;

  function automatic logic hit(input logic [7:0] ofs);
    hit = MPU_WR && (MPU_ADDR == ofs);
  endfunction

  // Write-only registers; narrow fields keep only their low bits
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      map_r <= `RPM_RST_MAP;
      sig_dly_r <= `RPM_RST_SIGDLY;
      tx_bofs_r <= `RPM_RST_BITOFS;
      rx_bofs_r <= `RPM_RST_BITOFS;
      tx_fofs_r <= `RPM_RST_FRMOFS;
      rx_fofs_r <= `RPM_RST_FRMOFS;
      fbits_r <= `RPM_RST_FBITS;
      mflen_r <= `RPM_RST_MFLEN;
      mfcnt_r <= `RPM_RST_MFCNT;
    end else if (hit(`RPM_OFS_PSEL0)) begin
      map_r[5:0] <= MPU_WDATA[5:0];
    end else if (hit(`RPM_OFS_PSEL1)) begin
      map_r[11:6] <= MPU_WDATA[5:0];
    end else if (hit(`RPM_OFS_PSEL2)) begin
      map_r[17:12] <= MPU_WDATA[5:0];
    end else if (hit(`RPM_OFS_PSEL3)) begin
      map_r[23:18] <= MPU_WDATA[5:0];
    end else if (hit(`RPM_OFS_PSEL4)) begin
      map_r[29:24] <= MPU_WDATA[5:0];
    end else if (hit(`RPM_OFS_PSEL5)) begin
      map_r[35:30] <= MPU_WDATA[5:0];
    end else if (hit(`RPM_OFS_SIGDLY)) begin
      sig_dly_r <= MPU_WDATA[3:0];
    end else if (hit(`RPM_OFS_TXBIT_LO)) begin
      tx_bofs_r[7:0] <= MPU_WDATA;
    end else if (hit(`RPM_OFS_TXBIT_HI)) begin
      tx_bofs_r[8] <= MPU_WDATA[`RPM_HI_BIT];
    end else if (hit(`RPM_OFS_TXFRM)) begin
      tx_fofs_r <= MPU_WDATA[5:0];
    end else if (hit(`RPM_OFS_RXBIT_LO)) begin
      rx_bofs_r[7:0] <= MPU_WDATA;
    end else if (hit(`RPM_OFS_RXBIT_HI)) begin
      rx_bofs_r[8] <= MPU_WDATA[`RPM_HI_BIT];
    end else if (hit(`RPM_OFS_RXFRM)) begin
      rx_fofs_r <= MPU_WDATA[5:0];
    end else if (hit(`RPM_OFS_MFLEN)) begin
      mflen_r <= MPU_WDATA[5:0];
    end else if (hit(`RPM_OFS_MFCNT)) begin
      mfcnt_r <= MPU_WDATA[5:0];
    end else if (hit(`RPM_OFS_FBITS_LO)) begin
      fbits_r[7:0] <= MPU_WDATA;
    end else if (hit(`RPM_OFS_FBITS_HI)) begin
      fbits_r[8] <= MPU_WDATA[`RPM_HI_BIT];
    end
  end

  // Error counter clear: data value ignored, nothing else touched
  assign wr_errclr = hit(`RPM_OFS_ERRCLR);
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ERR_COUNT_CLEAR <= 1'b0;
    end else begin
      ERR_COUNT_CLEAR <= wr_errclr;
    end
  end

  // Payload mapper; index past the block end waits for the next block start
  logic [5:0] byte_idx_r, byte_cur;
  assign byte_cur = PAYLOAD_BLOCK_START ? 6'h00 : byte_idx_r;
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      byte_idx_r <= 6'd36;
      STORE_WR <= 1'b0;
      STORE_DATA <= 8'h00;
    end else begin
      STORE_WR <= 1'b0;
      if (RECEIVE_STORE_FLUSH) begin
        byte_idx_r <= 6'd36;
      end else if (PAYLOAD_VALID && byte_cur < 6'd36) begin
        byte_idx_r <= byte_cur + 6'h01;
        STORE_WR <= map_r[byte_cur];
        STORE_DATA <= PAYLOAD_BYTE;
      end
    end
  end

  // Pin synchronisers; edge detection compares the second and third stages
  logic [2:0] tx_bit_clock_s, rclk_s, tsync_s;
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      tx_bit_clock_s <= 3'h0;
      rclk_s <= 3'h0;
      tsync_s <= 3'h0;
    end else begin
      tx_bit_clock_s <= {tx_bit_clock_s[1:0], TX_BIT_CLOCK};
      rclk_s <= {rclk_s[1:0], RX_BIT_CLOCK};
      tsync_s <= {tsync_s[1:0], TX_MULTIFRAME_SYNC_IN};
    end
  end
  logic tx_tick, rx_tick, tsync_rise;
  assign tx_tick = tx_bit_clock_s[1] & ~tx_bit_clock_s[2];
  assign rx_tick = rclk_s[1] & ~rclk_s[2];
  assign tsync_rise = tsync_s[1] & ~tsync_s[2];

  // Shared counter arithmetic
  function automatic logic last_bit(input rpm_bits_t pos, input rpm_bits_t len);
    last_bit = (pos == len);
  endfunction

  // Transmit timebase
  logic [5:0] tx_mf_r;
  logic tx_frame_end, tx_mf_end, tx_6ms_end, tx_align;
  assign tx_frame_end = last_bit(TX_BIT_POS, fbits_r);
  assign tx_mf_end = tx_frame_end && (TX_FRAME_POS == mflen_r);
  assign tx_6ms_end = tx_mf_end && (tx_mf_r == mfcnt_r);
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      TX_BIT_POS <= 9'h000;
      TX_FRAME_POS <= 6'h00;
      tx_mf_r <= 6'h00;
    end else if (tx_align) begin
      TX_BIT_POS <= 9'h000;
      TX_FRAME_POS <= 6'h00;
      tx_mf_r <= 6'h00;
    end else if (tx_tick) begin
      TX_BIT_POS <= tx_frame_end ? 9'h000 : TX_BIT_POS + 9'h001;
      if (tx_frame_end) begin
        TX_FRAME_POS <= tx_mf_end ? 6'h00 : TX_FRAME_POS + 6'h01;
      end
      if (tx_mf_end) begin
        tx_mf_r <= tx_6ms_end ? 6'h00 : tx_mf_r + 6'h01;
      end
    end
  end
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      TX_SLOT_STROBE <= 1'b0;
      TX_6MS_MARK <= 1'b0;
      DERIVED_TX_SYNC_OUT <= 1'b0;
    end else begin
      TX_SLOT_STROBE <= tx_tick && (TX_BIT_POS[2:0] == 3'h7);
      TX_6MS_MARK <= tx_align || (tx_tick && tx_6ms_end);
      if (tx_align || (tx_tick && tx_mf_end)) begin
        DERIVED_TX_SYNC_OUT <= 1'b1;
      end else if (tx_tick) begin
        DERIVED_TX_SYNC_OUT <= 1'b0;
      end
    end
  end

  // Transmit sync delay: offset+3 bits, then offset+1 frames
  rpm_dly_state_t txd_st_r;
  rpm_bits_t txd_bits_r;
  rpm_frm_t txd_frm_r;
  assign tx_align = tx_tick && (txd_st_r == DLY_FRAMES) && last_bit(txd_bits_r, fbits_r)
                    && (txd_frm_r == tx_fofs_r);
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      txd_st_r <= DLY_IDLE;
      txd_bits_r <= 9'h000;
      txd_frm_r <= 6'h00;
    end else if (tsync_rise) begin
      txd_st_r <= DLY_BITS;
      txd_bits_r <= 9'h000;
      txd_frm_r <= 6'h00;
    end else if (tx_tick) begin
      case (txd_st_r)
        DLY_BITS: begin
          if (txd_bits_r == tx_bofs_r + `RPM_TX_BIT_BASE) begin
            txd_st_r <= DLY_FRAMES;
            txd_bits_r <= 9'h000;
          end else begin
            txd_bits_r <= txd_bits_r + 9'h001;
          end
        end
        DLY_FRAMES: begin
          if (last_bit(txd_bits_r, fbits_r)) begin
            txd_bits_r <= 9'h000;
            txd_frm_r <= txd_frm_r + 6'h01;
            if (txd_frm_r == tx_fofs_r) begin
              txd_st_r <= DLY_IDLE;
            end
          end else begin
            txd_bits_r <= txd_bits_r + 9'h001;
          end
        end
        default: begin
          txd_st_r <= DLY_IDLE;
        end
      endcase
    end
  end
  // Ticks spent in the bit phase, counted apart from the delay counter
  logic [9:0] tsync_ticks_r;
  always_ff @(posedge MCLK) begin
    if (SRST || tsync_rise) begin
      tsync_ticks_r <= 10'h000;
    end else if (tx_tick && (txd_st_r == DLY_BITS)) begin
      tsync_ticks_r <= tsync_ticks_r + 10'h001;
    end
  end

  // Receive timebase; a master HDSL 6 ms mark is held until the next bit edge
  logic [5:0] rx_mf_r;
  logic rx_frame_end, rx_mf_end, rx_6ms_end, rx_pend_r, rx_align;
  assign rx_frame_end = last_bit(RX_BIT_POS, fbits_r);
  assign rx_mf_end = rx_frame_end && (RX_FRAME_POS == mflen_r);
  assign rx_6ms_end = rx_mf_end && (rx_mf_r == mfcnt_r);
  assign rx_align = rx_tick && (rx_pend_r || HDSL_RX_6MS_SYNC);
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      rx_pend_r <= 1'b0;
    end else if (HDSL_RX_6MS_SYNC) begin
      rx_pend_r <= !rx_tick;
    end else if (rx_tick) begin
      rx_pend_r <= 1'b0;
    end
  end
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      RX_BIT_POS <= 9'h000;
      RX_FRAME_POS <= 6'h00;
      rx_mf_r <= 6'h00;
    end else if (rx_align) begin
      RX_BIT_POS <= 9'h000;
      RX_FRAME_POS <= 6'h00;
      rx_mf_r <= 6'h00;
    end else if (rx_tick) begin
      RX_BIT_POS <= rx_frame_end ? 9'h000 : RX_BIT_POS + 9'h001;
      if (rx_frame_end) begin
        RX_FRAME_POS <= rx_mf_end ? 6'h00 : RX_FRAME_POS + 6'h01;
      end
      if (rx_mf_end) begin
        rx_mf_r <= rx_6ms_end ? 6'h00 : rx_mf_r + 6'h01;
      end
    end
  end
  logic rx_frm_start, rx_mf_start;
  assign rx_frm_start = rx_align || (rx_tick && rx_frame_end);
  assign rx_mf_start = rx_align || (rx_tick && rx_mf_end);
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      RX_SLOT_STROBE <= 1'b0;
      RX_6MS_MARK <= 1'b0;
    end else begin
      RX_SLOT_STROBE <= rx_tick && (RX_BIT_POS[2:0] == 3'h7);
      RX_6MS_MARK <= rx_align || (rx_tick && rx_6ms_end);
    end
  end

  // Receive sync output: bit delay then frame delay, timebase untouched
  rpm_dly_state_t rxd_st_r;
  rpm_bits_t rxd_bits_r;
  rpm_frm_t rxd_frm_r;
  logic rxd_fire;
  assign rxd_fire = rx_tick && (((rxd_st_r == DLY_BITS) && (rxd_bits_r + 9'h001 >= rx_bofs_r)
                    && (rx_fofs_r == 6'h00)) || ((rxd_st_r == DLY_FRAMES)
                    && last_bit(rxd_bits_r, fbits_r) && (rxd_frm_r + 6'h01 == rx_fofs_r)));
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      rxd_st_r <= DLY_IDLE;
      rxd_bits_r <= 9'h000;
      rxd_frm_r <= 6'h00;
    end else if (rx_mf_start) begin
      rxd_st_r <= DLY_BITS;
      rxd_bits_r <= 9'h000;
      rxd_frm_r <= 6'h00;
    end else if (rx_tick) begin
      case (rxd_st_r)
        DLY_BITS: begin
          rxd_bits_r <= 9'h000;
          if (rxd_bits_r + 9'h001 < rx_bofs_r) begin
            rxd_bits_r <= rxd_bits_r + 9'h001;
          end else if (rx_fofs_r == 6'h00) begin
            rxd_st_r <= DLY_IDLE;
          end else begin
            rxd_st_r <= DLY_FRAMES;
          end
        end
        DLY_FRAMES: begin
          if (last_bit(rxd_bits_r, fbits_r)) begin
            rxd_bits_r <= 9'h000;
            rxd_frm_r <= rxd_frm_r + 6'h01;
            if (rxd_frm_r + 6'h01 == rx_fofs_r) begin
              rxd_st_r <= DLY_IDLE;
            end
          end else begin
            rxd_bits_r <= rxd_bits_r + 9'h001;
          end
        end
        default: begin
          rxd_st_r <= DLY_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      RX_MULTIFRAME_SYNC_OUT <= 1'b0;
    end else if (rxd_fire) begin
      RX_MULTIFRAME_SYNC_OUT <= 1'b1;
    end else if (rx_tick) begin
      RX_MULTIFRAME_SYNC_OUT <= 1'b0;
    end
  end

  // Signaling frame 0 locator; a count in flight ignores new multiframe starts,
  // so a 16-frame delay still lands when multiframes are shorter than the delay
  logic sig_act_r;
  logic [3:0] sig_cnt_r;
  logic sig_done;
  assign sig_done = rx_frm_start && sig_act_r && (sig_cnt_r == 4'h0);
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      sig_act_r <= 1'b0;
      sig_cnt_r <= 4'h0;
      SIG_FRAME0_MARK <= 1'b0;
    end else if (!SIGNALING_GROOM_ENABLE) begin
      sig_act_r <= 1'b0;
      SIG_FRAME0_MARK <= rx_mf_start;
    end else begin
      SIG_FRAME0_MARK <= sig_done;
      if (rx_mf_start && (!sig_act_r || sig_done)) begin
        sig_act_r <= 1'b1;
        sig_cnt_r <= sig_dly_r;
      end else if (sig_done) begin
        sig_act_r <= 1'b0;
      end else if (rx_frm_start && sig_act_r) begin
        sig_cnt_r <= sig_cnt_r - 4'h1;
      end
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  chk_map_drop: assert property (PAYLOAD_VALID && PAYLOAD_BLOCK_START && !RECEIVE_STORE_FLUSH && !map_r[0]
    |=> !STORE_WR) else $error("dropped byte was stored");
  chk_map_keep: assert property (PAYLOAD_VALID && PAYLOAD_BLOCK_START && !RECEIVE_STORE_FLUSH && map_r[0]
    |=> STORE_WR && STORE_DATA == $past(PAYLOAD_BYTE)) else $error("byte 1 not stored");
  chk_err_clear: assert property (wr_errclr |=> ERR_COUNT_CLEAR ##1 (!ERR_COUNT_CLEAR || $past(wr_errclr)))
    else $error("clear strobe wrong");
  chk_err_only: assert property (!wr_errclr |=> !ERR_COUNT_CLEAR) else $error("spurious clear");
  chk_sig_bypass: assert property (!SIGNALING_GROOM_ENABLE && rx_mf_start |=> SIG_FRAME0_MARK)
    else $error("ungroomed frame 0 missed");
  chk_sig_zero: assert property (SIGNALING_GROOM_ENABLE && rx_mf_start && !sig_act_r
    |=> !SIG_FRAME0_MARK) else $error("early signaling mark");
  chk_sig_edge: assert property (SIG_FRAME0_MARK |-> $past(rx_frm_start)) else $error("mark off frame edge");
  chk_tx_align: assert property (tx_align |=> TX_BIT_POS == 9'h000 && TX_FRAME_POS == 6'h00
    && DERIVED_TX_SYNC_OUT && TX_6MS_MARK) else $error("tx timebase not aligned");
  chk_tx_wrap: assert property (tx_tick && !tx_align && tx_frame_end |=> TX_BIT_POS == 9'h000)
    else $error("tx frame wrap wrong");
  chk_rx_hdsl: assert property (rx_align |=> RX_BIT_POS == 9'h000 && RX_FRAME_POS == 6'h00)
    else $error("rx timebase ignored HDSL frame");
  chk_tx_bits: assert property (txd_st_r == DLY_BITS ##1 txd_st_r == DLY_FRAMES
    |-> tsync_ticks_r == {1'b0, tx_bofs_r} + {1'b0, `RPM_TX_BIT_BASE} + 10'h001) else $error("tx bit delay wrong");

  cov_tx_aligned: cover property (tx_align);
  cov_rx_sync: cover property (rxd_fire);
  cov_sig_grooming: cover property (SIGNALING_GROOM_ENABLE && SIG_FRAME0_MARK);
  cov_map_write: cover property (STORE_WR);

endmodule // rpm_map_formatter
`default_nettype wire

// ---- rtl/rpm_defines.svh ----
/*
  Offsets, reset values and timing counts of the payload mapper and PCM formatter.
  Included by the package and by the block; defines only.
*/
`ifndef RPM_DEFINES_SVH
`define RPM_DEFINES_SVH

// Register offsets on the processor write port
`define RPM_OFS_PSEL0 8'h64
`define RPM_OFS_PSEL1 8'h65
`define RPM_OFS_PSEL2 8'h66
`define RPM_OFS_ERRCLR 8'h67
`define RPM_OFS_SIGDLY 8'h68
`define RPM_OFS_PSEL3 8'h69
`define RPM_OFS_PSEL4 8'h6a
`define RPM_OFS_PSEL5 8'h6b
`define RPM_OFS_TXBIT_LO 8'hc0
`define RPM_OFS_TXBIT_HI 8'hc1
`define RPM_OFS_TXFRM 8'hc2
`define RPM_OFS_RXBIT_LO 8'hc3
`define RPM_OFS_RXBIT_HI 8'hc4
`define RPM_OFS_RXFRM 8'hc5
`define RPM_OFS_MFLEN 8'hc6
`define RPM_OFS_MFCNT 8'hc7
`define RPM_OFS_FBITS_LO 8'hc8
`define RPM_OFS_FBITS_HI 8'hc9

// Field widths and positions
`define RPM_SEL_W 6
`define RPM_MAP_W 36
`define RPM_HI_BIT 0

// Reset values
`define RPM_RST_MAP 36'h0
`define RPM_RST_SIGDLY 4'h0
`define RPM_RST_BITOFS 9'h000
`define RPM_RST_FRMOFS 6'h00
`define RPM_RST_FBITS 9'h0ff
`define RPM_RST_MFLEN 6'h0f
`define RPM_RST_MFCNT 6'h02

// Timing counts: transmit bit delay base in bit clock periods, synchroniser stage count
`define RPM_TX_BIT_BASE 9'h002
`define RPM_SYNC_STAGES 2

`endif

// ---- rtl/rpm_pkg.sv ----
/*
  Types shared by the payload mapper and PCM formatter.
  Assumes rpm_defines.svh is on the include path.
*/
`default_nettype none
package rpm_pkg;
  `include "rpm_defines.svh"
  typedef enum logic [1:0] {DLY_IDLE, DLY_BITS, DLY_FRAMES} rpm_dly_state_t;
  typedef logic [8:0] rpm_bits_t;
  typedef logic [5:0] rpm_frm_t;
endpackage
`default_nettype wire

// ---- test/rpm_pcm_bus_model.sv ----
/*
  Behavioural PCM bus partner: free-running transmit and receive bit clocks
  and a transmit multiframe sync pulse on request.
  Assumes the bench raises fire once for each sync pulse it wants.
*/
`default_nettype none
module rpm_pcm_bus_model (
  // Request from bench
  input wire logic fire,
  // PCM pins
  output logic tx_clk,
  output logic rx_clk,
  output logic tx_multiframe_sync_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tx_clk = 1'b0;
    rx_clk = 1'b0;
    tx_multiframe_sync_in = 1'b0;
  end
  // Bit clocks run free; phases unrelated to the system clock
  always #160 tx_clk = ~tx_clk;
  initial begin
    #57;
    forever #160 rx_clk = ~rx_clk;
  end
  // Sync rises mid-bit so no tick lands on its edge
  always @(posedge fire) begin
    @(negedge tx_clk);
    tx_multiframe_sync_in = 1'b1;
    repeat (4) @(negedge tx_clk);
    tx_multiframe_sync_in = 1'b0;
  end
endmodule // rpm_pcm_bus_model
`default_nettype wire

// ---- test/rpm_map_formatter_tb.sv ----
/*
  Self-checking bench of the payload mapper and PCM formatter timebases.
  Assumes the partner model makes the PCM bit clocks and transmit sync.
*/
`default_nettype none
module rpm_map_formatter_tb;
  import rpm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic pvalid = 1'b0;
  logic pstart = 1'b0;
  logic [7:0] pbyte = 8'h00;
  logic flush = 1'b0;
  logic groom = 1'b0;
  logic hsync = 1'b0;
  logic fire = 1'b0;
  logic tx_clk, rx_clk, tx_multiframe_sync_in;
  logic store_wr, err_clr, sig_mark, dsync, rsync, tslot, t6ms, rslot, r6ms;
  logic [7:0] store_data;
  logic [8:0] tbit, rbit;
  logic [5:0] tfrm, rfrm;
  int bad_count = 0;
  int compares = 0;
  int tx_ticks = 0;
  int rx_ticks = 0;
  int tx_slots = 0;
  int rx_slots = 0;
  int rx_6ms = 0;
  int clr_pulses = 0;
  int ts_tick = 0;
  int m6_last = 0;
  int m6_prev = 0;
  logic [7:0] stored [$];

  always #20 mclk = ~mclk;
  always @(posedge tx_clk) tx_ticks++;
  always @(posedge rx_clk) rx_ticks++;
  always @(posedge tx_multiframe_sync_in) ts_tick = tx_ticks;
  // Sampled mid-cycle, where registered outputs have settled
  always @(negedge mclk) begin
    if (store_wr === 1'b1) stored.push_back(store_data);
    if (err_clr === 1'b1) clr_pulses++;
    if (tslot === 1'b1) tx_slots++;
    if (rslot === 1'b1) rx_slots++;
    if (r6ms === 1'b1) rx_6ms++;
    if (t6ms === 1'b1) begin
      m6_prev = m6_last;
      m6_last = tx_ticks;
    end
  end

  rpm_map_formatter rpm_map_formatter_i (.MCLK(mclk), .SRST(srst), .MPU_WR(wr), .MPU_ADDR(addr),
    .MPU_WDATA(wdata), .PAYLOAD_VALID(pvalid), .PAYLOAD_BLOCK_START(pstart), .PAYLOAD_BYTE(pbyte),
    .RECEIVE_STORE_FLUSH(flush), .STORE_WR(store_wr), .STORE_DATA(store_data), .ERR_COUNT_CLEAR(err_clr),
    .SIGNALING_GROOM_ENABLE(groom), .SIG_FRAME0_MARK(sig_mark), .TX_BIT_CLOCK(tx_clk),
    .TX_MULTIFRAME_SYNC_IN(tx_multiframe_sync_in), .DERIVED_TX_SYNC_OUT(dsync), .TX_BIT_POS(tbit), .TX_FRAME_POS(tfrm),
    .TX_SLOT_STROBE(tslot), .TX_6MS_MARK(t6ms), .RX_BIT_CLOCK(rx_clk), .HDSL_RX_6MS_SYNC(hsync),
    .RX_MULTIFRAME_SYNC_OUT(rsync), .RX_BIT_POS(rbit), .RX_FRAME_POS(rfrm), .RX_SLOT_STROBE(rslot),
    .RX_6MS_MARK(r6ms));
  rpm_pcm_bus_model rpm_pcm_bus_model_i (.fire(fire), .tx_clk(tx_clk), .rx_clk(rx_clk), .tx_multiframe_sync_in(tx_multiframe_sync_in));

  task automatic finish_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge mclk);
    wr = 1'b0;
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return dsync;
      1: return rsync;
      2: return sig_mark;
      default: return t6ms;
    endcase
  endfunction

  task automatic wait_lvl(input int w, input logic lvl);
    int n;
    n = 0;
    @(negedge mclk);
    while (pick(w) !== lvl) begin
      n++;
      if (n > 7000) begin
        bad_count++;
        $display("wrong value wait %0d expected %0h seen timeout", w, lvl);
        finish_test();
      end
      @(negedge mclk);
    end
  endtask

  task automatic wait_rise(input int w);
    wait_lvl(w, 1'b0);
    wait_lvl(w, 1'b1);
  endtask

  task automatic test_payload();
    logic [7:0] exp [$];
    wr_reg(8'h64, 8'hc5);
    wr_reg(8'h65, 8'h01);
    wr_reg(8'h66, 8'h41);
    wr_reg(8'h6b, 8'h20);
    @(negedge mclk);
    flush = 1'b1;
    @(negedge mclk);
    flush = 1'b0;
    pvalid = 1'b1;
    pbyte = 8'hff;
    // Stray byte before block start must be dropped; byte 37 too
    for (int i = 0; i < 37; i++) begin
      @(negedge mclk);
      pstart = (i == 0);
      pbyte = 8'h40 + i[7:0];
    end
    @(negedge mclk);
    pvalid = 1'b0;
    pstart = 1'b0;
    repeat (3) @(negedge mclk);
    exp = '{8'h40, 8'h42, 8'h46, 8'h4c, 8'h63};
    chk("store count", 16'(exp.size()), 16'(stored.size()));
    foreach (exp[k]) chk("store byte", {8'h00, exp[k]}, {8'h00, stored[k]});
  endtask

  task automatic test_err_clear();
    wr_reg(8'h63, 8'h5a);
    wr_reg(8'h67, 8'h00);
    wr_reg(8'h67, 8'hff);
    repeat (2) @(negedge mclk);
    chk("clear pulses", 16'd2, 16'(clr_pulses));
  endtask

  task automatic setup_timebase();
    wr_reg(8'hc8, 8'h0f);
    wr_reg(8'hc9, 8'hfe);
    wr_reg(8'hc6, 8'h03);
    wr_reg(8'hc7, 8'h0b);
  endtask

  task automatic test_tx(input logic [8:0] bofs, input logic [5:0] fofs);
    wr_reg(8'hc0, bofs[7:0]);
    wr_reg(8'hc1, {7'h00, bofs[8]});
    wr_reg(8'hc2, {2'b00, fofs});
    // Start right after a multiframe wrap so no free-run multiframe wrap lands inside the delay
    wait_rise(0);
    fire = 1'b1;
    wait_rise(0);
    fire = 1'b0;
    chk("tx sync ticks", 16'(bofs + 16'd3 + (fofs + 16'd1) * 16'd16), 16'(tx_ticks - ts_tick));
    chk("tx bit pos", 16'h0, {7'h00, tbit});
    chk("tx frame pos", 16'h0, {10'h000, tfrm});
    chk("tx 6ms mark", 16'h1, {15'h0000, t6ms});
  endtask

  task automatic test_free_run();
    int t1;
    int s1;
    // Let the counting process see the current cycle before sampling counts
    @(posedge mclk);
    t1 = tx_ticks;
    s1 = tx_slots;
    wait_rise(0);
    @(posedge mclk);
    chk("tx mframe ticks", 16'd64, 16'(tx_ticks - t1));
    chk("tx slot strobes", 16'd8, 16'(tx_slots - s1));
    wait_rise(3);
    @(posedge mclk);
    chk("tx 6ms ticks", 16'd768, 16'(m6_last - m6_prev));
  endtask

  task automatic test_rx();
    int r0;
    int m0;
    int s0;
    wr_reg(8'hc3, 8'h05);
    wr_reg(8'hc4, 8'hfe);
    wr_reg(8'hc5, 8'h01);
    wait_rise(1);
    @(negedge rx_clk);
    @(negedge mclk);
    hsync = 1'b1;
    r0 = rx_ticks;
    m0 = rx_6ms;
    @(negedge mclk);
    hsync = 1'b0;
    wait_rise(1);
    chk("rx sync ticks", 16'd22, 16'(rx_ticks - r0));
    chk("rx bit pos", 16'd5, {7'h00, rbit});
    chk("rx frame pos", 16'd1, {10'h000, rfrm});
    chk("rx 6ms marks", 16'd1, 16'(rx_6ms - m0));
    // One free-running multiframe between two receive sync rises
    r0 = rx_ticks;
    s0 = rx_slots;
    wait_rise(1);
    chk("rx mframe ticks", 16'd64, 16'(rx_ticks - r0));
    chk("rx slot strobes", 16'd8, 16'(rx_slots - s0));
  endtask

  task automatic test_sig(input logic en, input logic [3:0] d, input logic [5:0] frm);
    wr_reg(8'h68, {4'hf, d});
    @(negedge mclk);
    groom = en;
    // First mark may still follow the old setting
    wait_rise(2);
    wait_rise(2);
    chk("mark frame", {10'h000, frm}, {10'h000, rfrm});
    chk("mark bit", 16'h0, {7'h00, rbit});
  endtask

  initial begin
    repeat (10) @(negedge mclk);
    srst = 1'b0;
    test_payload();
    test_err_clear();
    setup_timebase();
    test_tx(9'h000, 6'h00);
    test_tx(9'h002, 6'h01);
    test_tx(9'h00d, 6'h00);
    test_free_run();
    test_rx();
    test_sig(1'b0, 4'h1, 6'h00);
    test_sig(1'b1, 4'h1, 6'h02);
    test_sig(1'b1, 4'hf, 6'h00);
    finish_test();
  end
endmodule // rpm_map_formatter_tb
`default_nettype wire
